// ===== hdl/sti_buf2.sv
// Purpose: Small valid/ready buffer in the word path.
// Assumes: Single clock, asynchronous active-high reset.
// Notes:   Entries are flip-flops; read data come from the entry registers.
`timescale 1ns/100ps
module sti_buf2
  import sti_pkg::*;
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
)(
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sti_buf2 needs a power-of-two depth of at least two.");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q < (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

// ===== hdl/sti_toh_insert.sv
// Purpose: Transmit transport overhead handling for one STS-48 word stream.
// Assumes: Words and frame marker come from fabric logic on i_ref_clk.
// Notes:   Registers over APB; a two-entry buffer decouples the output.
`timescale 1ns/100ps
`include "sti_regs.svh"
module sti_toh_insert
  import sti_pkg::*;
#(
  parameter int ROWS      = `STI_ROWS,
  parameter int OH_WORDS  = `STI_OH_WORDS,
  parameter int PAY_WORDS = `STI_PAY_WORDS
)(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`STI_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire logic                   i_in_valid,
  input  wire sti_word_s              i_in_word,
  output logic                        o_in_ready,
  output logic                        o_out_valid,
  output sti_word_s                   o_out_word,
  input  wire logic                   i_out_ready
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  localparam int ROW_WORDS = OH_WORDS + PAY_WORDS;

  generate
    if (OH_WORDS != 3 * `STI_WORDS_PER_COL || ROWS < 1 || ROWS > 15
        || ROW_WORDS > 2047) begin : g_bad_geometry
      $error("sti_toh_insert: unsupported frame geometry.");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  logic [7:0]  par_hold_q;
  logic [7:0]  par_acc_q;
  logic [15:0] fcnt_q;
  logic [10:0] col_q;
  logic [3:0]  row_q;
  logic        sync_q;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        apb_wr;
  logic [31:0] stat_word;

  assign hit_ctrl  = (i_paddr == `STI_CTRL_OFS);
  assign hit_stat  = (i_paddr == `STI_STAT_OFS);
  assign apb_wr    = i_psel && i_penable && i_pwrite && o_pready;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit_ctrl && !hit_stat;
  assign o_prdata  = rdata_q;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`STI_STAT_PAR_HI:`STI_STAT_PAR_LO]   = par_hold_q;
    stat_word[`STI_STAT_ROW_HI:`STI_STAT_ROW_LO]   = row_q;
    stat_word[`STI_STAT_SYNC]                      = sync_q;
    stat_word[`STI_STAT_FCNT_HI:`STI_STAT_FCNT_LO] = fcnt_q;
  end

  // The mode and all enables live here, so each channel has exactly one mode.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= `STI_CTRL_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_q <= i_pwdata & `STI_CTRL_MASK;
    end
  end

  // Read data are captured in the setup cycle and stand through the access.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      if (hit_ctrl) begin
        rdata_q <= ctrl_q;
      end else if (hit_stat) begin
        rdata_q <= stat_word;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  sti_mode_e   mode;
  logic        frm_en;
  logic        par_en;
  logic        rdi_force;
  logic        frm_inv;
  logic        par_inv;
  logic [1:0]  blk;
  logic [7:0]  link_num;

  assign mode      = sti_mode_e'(ctrl_q[`STI_CTRL_MODE_HI:`STI_CTRL_MODE_LO]);
  assign frm_en    = ctrl_q[`STI_CTRL_FRM_EN];
  assign par_en    = ctrl_q[`STI_CTRL_PAR_EN];
  assign rdi_force = ctrl_q[`STI_CTRL_RDI];
  assign frm_inv   = ctrl_q[`STI_CTRL_FRM_INV];
  assign par_inv   = ctrl_q[`STI_CTRL_PAR_INV];
  assign blk       = ctrl_q[`STI_CTRL_BLK_HI:`STI_CTRL_BLK_LO];
  assign link_num  = ctrl_q[`STI_CTRL_LINK_HI:`STI_CTRL_LINK_LO];

  // --------------------------------------------------------------------------
  // Frame position
  // --------------------------------------------------------------------------
  logic        take;
  logic        sof;
  logic [10:0] cur_col;
  logic [3:0]  cur_row;
  logic        oh_act;
  logic [1:0]  oh_col;
  logic [3:0]  oh_word;
  logic [4:0]  pos_idx;
  logic        buf_in_ready;

  assign take    = i_in_valid && buf_in_ready;
  assign sof     = i_in_word.tx_frame_start_pulse;
  assign cur_col = sof ? 11'd0 : col_q;
  assign cur_row = sof ? 4'd0 : row_q;
  assign oh_act  = (sof || sync_q) && (cur_col < 11'(OH_WORDS));

  always_comb begin
    if (cur_col < 11'(`STI_WORDS_PER_COL)) begin
      oh_col  = 2'd0;
      oh_word = cur_col[3:0];
    end else if (cur_col < 11'(2 * `STI_WORDS_PER_COL)) begin
      oh_col  = 2'd1;
      oh_word = 4'(cur_col - 11'(`STI_WORDS_PER_COL));
    end else begin
      oh_col  = 2'd2;
      oh_word = 4'(cur_col - 11'(2 * `STI_WORDS_PER_COL));
    end
    pos_idx = {1'b0, cur_row} * 5'd3 + {3'b000, oh_col};
  end

  // Row and column advance on each accepted word; the marker restarts them.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      col_q <= 11'd0;
      row_q <= 4'd0;
    end else if (take) begin
      if (cur_col == 11'(ROW_WORDS - 1)) begin
        col_q <= 11'd0;
        row_q <= (cur_row == 4'(ROWS - 1)) ? 4'd0 : cur_row + 4'd1;
      end else begin
        col_q <= cur_col + 11'd1;
      end
    end
  end

  // Frames are only touched once a marker has been seen.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_q <= 1'b0;
      fcnt_q <= 16'h0000;
    end else if (take && sof) begin
      sync_q <= 1'b1;
      fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Lane order
  // --------------------------------------------------------------------------
  // STS-1 number carried in overhead word w, byte lane l (lane 0 = bits 31:24).
  function automatic logic [7:0] sts_id(input logic [3:0] w,
                                        input logic [1:0] lane,
                                        input logic [1:0] b);
    logic [7:0] base;
    logic [7:0] id;
    base = {6'h00, w[1:0]} * 8'h03 + {6'h00, w[3:2]};
    case (lane)
      2'd0:    id = base + 8'h01;
      2'd1:    id = 8'h18 - base;
      2'd2:    id = 8'h19 + base;
      default: id = 8'h30 - base;
    endcase
    return id + {6'h00, b} * 8'(`STI_STS_PER_CH);
  endfunction

  // --------------------------------------------------------------------------
  // Byte substitution, one lane per generate pass
  // --------------------------------------------------------------------------
  sti_word_s out_word;

  assign out_word.tx_frame_start_pulse = sof;

  for (genvar l = 0; l < 4; l++) begin : g_lane
    logic [7:0] in_b;
    logic [7:0] ob;
    logic [7:0] id;
    logic       first;

    assign in_b  = i_in_word.data[31-8*l -: 8];
    assign id    = sts_id(oh_word, 2'(l), blk);
    assign first = (oh_word == 4'd0) && (l == 0);
    assign out_word.data[31-8*l -: 8] = ob;

    always_comb begin
      ob = in_b;
      if (oh_act) begin
        case (mode)
          STI_MODE_SECTION: begin
            if (frm_en && pos_idx == `STI_POS_FRAME1) begin
              ob = `STI_FRAME1 ^ {8{frm_inv}};
            end else if (frm_en && pos_idx == `STI_POS_FRAME2) begin
              ob = `STI_FRAME2 ^ {8{frm_inv}};
            end else if (par_en && pos_idx == `STI_POS_PARITY) begin
              ob = first ? (par_hold_q ^ {8{par_inv}}) : 8'h00;
            end else if (rdi_force && first && pos_idx == `STI_POS_APS2) begin
              ob = `STI_RDI_PATTERN;
            end
          end
          STI_MODE_FULL: begin
            ob = 8'h00;
            if (pos_idx == `STI_POS_FRAME1) begin
              ob = `STI_FRAME1 ^ {8{frm_inv}};
            end else if (pos_idx == `STI_POS_FRAME2) begin
              ob = `STI_FRAME2 ^ {8{frm_inv}};
            end else if (pos_idx == `STI_POS_TRACE) begin
              ob = (id[1:0] == 2'b01) ? id : 8'h00;
            end else if (pos_idx == `STI_POS_PARITY) begin
              ob = first ? (par_hold_q ^ {8{par_inv}}) : 8'h00;
            end else if (pos_idx == `STI_POS_USER) begin
              ob = first ? link_num : 8'h00;
            end else if (pos_idx == `STI_POS_PTR1) begin
              ob = first ? `STI_PTR1_FIRST : `STI_PTR1_OTHER;
            end else if (pos_idx == `STI_POS_PTR2) begin
              ob = first ? `STI_PTR2_FIRST : `STI_PTR2_OTHER;
            end else if (pos_idx == `STI_POS_APS2 && first && rdi_force) begin
              ob = `STI_RDI_PATTERN;
            end
          end
          default: begin
            ob = in_b;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Section parity
  // --------------------------------------------------------------------------
  // Even parity per bit lane over every transmitted byte of a frame. It is
  // taken on the words as sent here, since no scrambler sits in this block.
  logic [7:0] word_fold;

  assign word_fold = out_word.data[31:24] ^ out_word.data[23:16]
                   ^ out_word.data[15:8] ^ out_word.data[7:0];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      par_acc_q <= 8'h00;
    end else if (take) begin
      par_acc_q <= (sof ? 8'h00 : par_acc_q) ^ word_fold;
    end
  end

  // The finished result moves to the hold register at the next marker, so the
  // parity of one frame is sent in the frame after it.
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      par_hold_q <= 8'h00;
    end else if (take && sof) begin
      par_hold_q <= sync_q ? par_acc_q : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Output buffer
  // --------------------------------------------------------------------------
  // A stall at the output back-pressures the fabric through o_in_ready.
  logic [32:0] buf_out;

  sti_buf2 #(
    .WIDTH (33),
    .DEPTH (2)
  ) u_buf (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_in_valid),
    .i_in_data   (out_word),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_out_valid),
    .o_out_data  (buf_out),
    .i_out_ready (i_out_ready)
  );

  assign o_in_ready = buf_in_ready;
  assign o_out_word = buf_out;

endmodule

// ===== inc/sti_pkg.sv
// Purpose: Types shared by the overhead insertion block and its buffer.
// Assumes: Constants live in sti_regs.svh.
// Notes:   None.
package sti_pkg;

  // --------------------------------------------------------------------------
  // Overhead modes
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    STI_MODE_TRANSP  = 2'b00,
    STI_MODE_SECTION = 2'b01,
    STI_MODE_FULL    = 2'b10,
    STI_MODE_RSVD    = 2'b11
  } sti_mode_e;

  // --------------------------------------------------------------------------
  // Stream word with its frame marker
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        tx_frame_start_pulse;
    logic [31:0] data;
  } sti_word_s;

endpackage

// ===== inc/sti_regs.svh
// Purpose: Register offsets, field positions, reset values and frame geometry
//          for the transmit overhead insertion block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef STI_REGS_SVH
`define STI_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define STI_ADDR_W        12
`define STI_CTRL_OFS      12'h000
`define STI_STAT_OFS      12'h004

// Control register fields.
`define STI_CTRL_MODE_LO  0
`define STI_CTRL_MODE_HI  1
`define STI_CTRL_FRM_EN   2
`define STI_CTRL_PAR_EN   3
`define STI_CTRL_RDI      4
`define STI_CTRL_FRM_INV  5
`define STI_CTRL_PAR_INV  6
`define STI_CTRL_BLK_LO   8
`define STI_CTRL_BLK_HI   9
`define STI_CTRL_LINK_LO  16
`define STI_CTRL_LINK_HI  23
`define STI_CTRL_RST      32'h0000_000C
`define STI_CTRL_MASK     32'h00FF_037F

// Status register fields.
`define STI_STAT_PAR_LO   0
`define STI_STAT_PAR_HI   7
`define STI_STAT_ROW_LO   8
`define STI_STAT_ROW_HI   11
`define STI_STAT_SYNC     12
`define STI_STAT_FCNT_LO  16
`define STI_STAT_FCNT_HI  31

// ----------------------------------------------------------------------------
// Inserted byte values
// ----------------------------------------------------------------------------
`define STI_FRAME1        8'hF6
`define STI_FRAME2        8'h28
`define STI_RDI_PATTERN   8'h06
`define STI_PTR1_FIRST    8'h62
`define STI_PTR1_OTHER    8'h93
`define STI_PTR2_FIRST    8'h0A
`define STI_PTR2_OTHER    8'hFF

// ----------------------------------------------------------------------------
// Frame geometry; row parts and overhead columns in word-clock cycles
// ----------------------------------------------------------------------------
`define STI_ROWS          9
`define STI_OH_WORDS      36
`define STI_PAY_WORDS     1044
`define STI_WORDS_PER_COL 12
`define STI_STS_PER_CH    48

// Overhead byte index = row * 3 + overhead column.
`define STI_POS_FRAME1    5'd0
`define STI_POS_FRAME2    5'd1
`define STI_POS_TRACE     5'd2
`define STI_POS_PARITY    5'd3
`define STI_POS_USER      5'd5
`define STI_POS_PTR1      5'd9
`define STI_POS_PTR2      5'd10
`define STI_POS_APS2      5'd14

`endif

// ===== tb/sti_fab_src.sv
// Purpose: Fabric source model that sends whole frames with bubbles.
// Assumes: Called just after a rising edge.
// Notes:   Accepted words are noted in order for the output monitor.
`timescale 1ns/100ps
module sti_fab_src
  import sti_pkg::*;
#(
  parameter int RW = 1080,
  parameter int FW = 9720
)(
  input  wire logic i_ref_clk,
  input  wire logic i_in_ready,
  output logic      o_in_valid,
  output sti_word_s o_in_word
);
  sti_word_s note_q[$];
  int        seed = 40569;
  logic [7:0] b2_q = 8'h00;
  initial begin
    o_in_valid = 1'b0;
    o_in_word  = '0;
  end
  task automatic send_frame();
    sti_word_s wd;
    logic [7:0] b2_acc;
    b2_acc = 8'h00;
    for (int i = 0; i < FW; i++) begin
      wd.tx_frame_start_pulse = (i == 0);
      wd.data = $random(seed);
      if (i / RW == 3 && i % RW >= 24 && i % RW < 36) wd.data = 32'h0000_0000;
      if (i / RW == 4 && i % RW < 12) wd.data = {4{b2_q}};
      if (i / RW >= 3 || i % RW >= 36) begin
        b2_acc ^= wd.data[31:24] ^ wd.data[23:16] ^ wd.data[15:8] ^ wd.data[7:0];
      end
      o_in_valid <= 1'b1;
      o_in_word  <= wd;
      do @(posedge i_ref_clk); while (i_in_ready !== 1'b1);
      note_q.push_back(wd);
      if ($random(seed) % 4 == 0) begin
        o_in_valid <= 1'b0;
        @(posedge i_ref_clk);
      end
    end
    b2_q = b2_acc;
    o_in_valid <= 1'b0;
    @(posedge i_ref_clk);
  endtask
endmodule

// ===== tb/sti_toh_checker.sv
// Purpose: Port-level checks of overhead substitution and buffering.
// Assumes: Control is shadowed from APB writes.
// Notes:   Bound to the top module after endmodule.
`timescale 1ns/100ps
`include "sti_regs.svh"
module sti_toh_checker
  import sti_pkg::*;
#(
  parameter int ROWS      = 9,
  parameter int OH_WORDS  = 36,
  parameter int PAY_WORDS = 1044
)(
  input wire logic                   i_ref_clk,
  input wire logic                   i_sys_rst,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`STI_ADDR_W-1:0] i_paddr,
  input wire logic [31:0]            i_pwdata,
  input wire logic [31:0]            o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic                   i_in_valid,
  input wire sti_word_s              i_in_word,
  input wire logic                   o_in_ready,
  input wire logic                   o_out_valid,
  input wire sti_word_s              o_out_word,
  input wire logic                   i_out_ready
);
  // --------------------------------------------------------------------------
  // Output word position
  // --------------------------------------------------------------------------
  logic [31:0] ctrl_q;
  int          cnt_q;
  int          cur, row, cw, w, pos;
  logic        ins, sect, full, first;
  // The count starts past the frame so nothing is judged before a marker.
  always_comb begin
    cur   = o_out_word.tx_frame_start_pulse ? 0 : cnt_q;
    row   = cur / (OH_WORDS + PAY_WORDS);
    cw    = cur % (OH_WORDS + PAY_WORDS);
    w     = cw % 12;
    pos   = row * 3 + cw / 12;
    first = (w == 0);
    ins   = o_out_valid && (cw < OH_WORDS) && (row < ROWS);
    sect  = (ctrl_q[1:0] == 2'b01);
    full  = (ctrl_q[1:0] == 2'b10);
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= ROWS * (OH_WORDS + PAY_WORDS);
    end else if (o_out_valid && i_out_ready) begin
      cnt_q <= cur + 1;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= `STI_CTRL_RST;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == `STI_CTRL_OFS) begin
      ctrl_q <= i_pwdata & `STI_CTRL_MASK;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_full_frame1: assert property (ins && full && pos == 0
    |-> o_out_word.data == (32'hF6F6F6F6 ^ {32{ctrl_q[5]}}))
    else $error("full mode first framing word wrong");
  chk_sect_frame2: assert property (ins && sect && ctrl_q[2] && pos == 1
    |-> o_out_word.data == (32'h28282828 ^ {32{ctrl_q[5]}}))
    else $error("second framing word wrong");
  chk_parity_others: assert property (ins && (full || sect && ctrl_q[3]) && pos == 3
    |-> o_out_word.data[23:0] == 24'h000000 && (first || o_out_word.data[31:24] == 8'h00))
    else $error("parity position of other channels not zero");
  chk_full_zeros: assert property (ins && full && (row == 2 || row >= 5)
    |-> o_out_word.data == 32'h00000000) else $error("full mode zero rows not zero");
  chk_rdi_k2: assert property (ins && (sect || full) && ctrl_q[4] && pos == 14 && first
    |-> o_out_word.data[31:24] == `STI_RDI_PATTERN) else $error("defect pattern missing");
  chk_full_ptr1: assert property (ins && full && pos == 9
    |-> o_out_word.data == (first ? 32'h62939393 : 32'h93939393)) else $error("pointer one wrong");
  chk_full_ptr2: assert property (ins && full && pos == 10
    |-> o_out_word.data == (first ? 32'h0AFFFFFF : 32'hFFFFFFFF)) else $error("pointer two wrong");
  chk_stall_hold: assert property (o_out_valid && !i_out_ready
    |=> o_out_valid && $stable(o_out_word)) else $error("stalled word changed");
  chk_refuse_full: assert property (!o_in_ready
    |-> o_out_valid and (i_out_ready |=> o_in_ready))
    else $error("full buffer did not drain");
  cover property (ins && full && pos == 0);
  cover property (ins && sect && ctrl_q[4] && pos == 14);
  cover property (!o_in_ready && i_in_valid);
endmodule

bind sti_toh_insert sti_toh_checker #(.ROWS(ROWS), .OH_WORDS(OH_WORDS), .PAY_WORDS(PAY_WORDS))
  u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_in_valid(i_in_valid), .i_in_word(i_in_word),
  .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_out_word(o_out_word),
  .i_out_ready(i_out_ready));

// ===== tb/sti_toh_insert_tb.sv
// Purpose: Self-checking bench for the overhead insertion block.
// Assumes: Rows shortened to 48 words; overhead width kept at 36 words.
// Notes:   Expected words are derived from the noted input words.
`timescale 1ns/100ps
`include "sti_regs.svh"
module sti_toh_insert_tb
  import sti_pkg::*;
;
  localparam int RW = 48;
  localparam int FW = 432;
  logic        i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
  logic        i_pwrite = 1'b0, i_out_ready = 1'b0, stall = 1'b0, er, o_pready, o_pslverr;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd, ctrl = `STI_CTRL_RST;
  logic        in_valid, o_in_ready, o_out_valid;
  sti_word_s   in_word, o_out_word, nw, ew;
  logic [7:0]  par_acc = 8'h00, par_hold = 8'h00;
  int          err_total = 0, total_checks = 0, seed = 40569, idx = 0;
  logic [31:0] cfg [9] = '{32'h0000_0000, 32'h0000_000D, 32'h0000_0005, 32'h0000_0009,
                           32'h0000_001D, 32'h005A_0112, 32'h0000_001F, 32'h0000_006D,
                           32'h0000_0262};
  always #20 i_ref_clk = ~i_ref_clk;
  sti_toh_insert #(.ROWS(9), .OH_WORDS(36), .PAY_WORDS(12)) dut (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_in_valid(in_valid), .i_in_word(in_word),
    .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .o_out_word(o_out_word),
    .i_out_ready(i_out_ready));
  sti_fab_src #(.RW(RW), .FW(FW)) src (.i_ref_clk(i_ref_clk), .i_in_ready(o_in_ready),
    .o_in_valid(in_valid), .o_in_word(in_word));
  // --------------------------------------------------------------------------
  // Tasks and expected values
  // --------------------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim();
    $display("Checks made %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_ref_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  function automatic sti_word_s expw(sti_word_s in, int i, logic [31:0] ct, logic [7:0] par);
    sti_word_s r;
    int        cw, w, pos, base, id;
    logic [7:0] b;
    logic      fs, fm, sm;
    r = in;
    cw = i % RW;
    w = cw % 12;
    pos = (i / RW) * 3 + cw / 12;
    fm = (ct[1:0] == 2'b10);
    sm = (ct[1:0] == 2'b01);
    base = (w % 4) * 3 + w / 4;
    if (cw < 36 && (sm || fm)) begin
      for (int l = 0; l < 4; l++) begin
        id = (l == 0) ? base + 1 : (l == 1) ? 24 - base : (l == 2) ? 25 + base : 48 - base;
        id = id + 48 * ct[9:8];
        fs = (w == 0 && l == 0);
        b = fm ? 8'h00 : in.data[31-8*l -: 8];
        if (pos == 0 && (fm || ct[2])) b = `STI_FRAME1 ^ {8{ct[5]}};
        if (pos == 1 && (fm || ct[2])) b = `STI_FRAME2 ^ {8{ct[5]}};
        if (pos == 3 && (fm || ct[3])) b = fs ? par ^ {8{ct[6]}} : 8'h00;
        if (fm && pos == 2 && id % 4 == 1) b = id[7:0];
        if (fm && pos == 5 && fs) b = ct[23:16];
        if (fm && pos == 9) b = fs ? `STI_PTR1_FIRST : `STI_PTR1_OTHER;
        if (fm && pos == 10) b = fs ? `STI_PTR2_FIRST : `STI_PTR2_OTHER;
        if (pos == 14 && fs && ct[4]) b = `STI_RDI_PATTERN;
        r.data[31-8*l -: 8] = b;
      end
    end
    return r;
  endfunction
  // --------------------------------------------------------------------------
  // Output side
  // --------------------------------------------------------------------------
  always @(posedge i_ref_clk) i_out_ready <= !stall && ($random(seed) % 3 != 0);
  always @(posedge i_ref_clk) begin
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
      if (src.note_q.size() == 0) chk(1'b0, "word without input");
      else begin
        nw = src.note_q.pop_front();
        if (nw.tx_frame_start_pulse) begin
          idx = 0;
          par_hold = par_acc;
          par_acc = 8'h00;
        end
        ew = expw(nw, idx, ctrl, par_hold);
        chk(o_out_word === ew, "output word mismatch");
        par_acc ^= ew.data[31:24] ^ ew.data[23:16] ^ ew.data[15:8] ^ ew.data[7:0];
        idx++;
      end
    end
  end
  initial begin
    #(40 * 60000);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    apb(1'b0, `STI_CTRL_OFS, 32'h0000_0000, rd, er);
    chk(rd === `STI_CTRL_RST, "control reset value");
    apb(1'b1, `STI_CTRL_OFS, 32'hFFFF_FFFF, rd, er);
    apb(1'b0, `STI_CTRL_OFS, 32'h0000_0000, rd, er);
    chk(rd === `STI_CTRL_MASK, "control readback");
    apb(1'b0, 12'h008, 32'h0000_0000, rd, er);
    chk(rd === 32'h0000_0000 && er === 1'b1, "unmapped access");
    foreach (cfg[k]) begin
      for (int t = 0; t < 2000 && src.note_q.size() != 0; t++) @(posedge i_ref_clk);
      apb(1'b1, `STI_CTRL_OFS, cfg[k], rd, er);
      ctrl = cfg[k] & `STI_CTRL_MASK;
      fork
        repeat (2) src.send_frame();
        if (k == 0) begin
          stall <= 1'b1;
          repeat (8) @(posedge i_ref_clk);
          chk(o_in_ready === 1'b0 && o_out_valid === 1'b1, "full buffer refusal");
          stall <= 1'b0;
        end
      join
    end
    for (int t = 0; t < 2000 && src.note_q.size() != 0; t++) @(posedge i_ref_clk);
    chk(src.note_q.size() == 0, "words left in flight");
    apb(1'b0, `STI_STAT_OFS, 32'h0000_0000, rd, er);
    chk(rd === {16'(2 * $size(cfg)), 4'h1, 4'h0, par_hold} && er === 1'b0, "status");
    end_sim();
  end
endmodule
